// File: core/sfp_regs.svh
// constants of the stop-frequency command parser
// assumes inclusion by bare name from package and core module
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH
`define SFP_STB_SETTLED_BIT 3
`define SFP_STB_RESET 8'h00
`define SFP_BAND1_EDGE_KHZ 40'd6600000
`define SFP_BAND2_EDGE_KHZ 40'd12300000
`define SFP_SETTLE_TIME_NS 1000
`define SFP_CLK_PERIOD_NS 8
`define SFP_SETTLE_CYC ((`SFP_SETTLE_TIME_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)
`define SFP_FRAC_MAX 4'd9
`endif

// File: core/sfp_pkg.sv
// types shared by the stop-frequency command parser
// assumes sfp_regs.svh is on the include path
`include "sfp_regs.svh"
package sfp_pkg;
	typedef enum {
		SFP_IDLE, SFP_CODE2, SFP_NUM, SFP_UNIT2, SFP_SUFFIX2, SFP_CS2, SFP_CALC, SFP_SETTLE, SFP_SEND
	} sfp_state_e;
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} sfp_byte_s;
	typedef struct packed {
		logic [39:0] khz_value;
		logic [1:0] band;
	} sfp_freq_s;
endpackage : sfp_pkg

// File: core/sfp_parser.sv
// stop-frequency command parser: ascii in, frequency, status byte and readback out
// assumes i_rx bytes and the poll strobe come from logic on i_sys_clk
// Notes on behaviour
// - code, decimal number, then unit terminator
// - letters accepted in any case
// - below 6.6 GHz round to 1 kHz
// - middle band grid of 2 kHz
// - top band grid of 3 kHz
// - exact only if kHz divides by multiplier
// - between grid points pick a neighbour
// - settled flag set after new frequency valid
// - clear-status code drops settled flag
// - flag latched until poll or clear
// - keypad display justification, panel side only
// - readback suffix returns stop frequency in Hz
// - settled flag is status bit 3
// - new stop sets span and centre
`timescale 1ns/100ps
`include "sfp_regs.svh"
module sfp_parser (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire sfp_pkg::sfp_byte_s i_rx, // received ascii character
	input wire logic i_poll, // serial poll read strobe
	input wire logic [39:0] i_start_hz, // current sweep start in Hz
	output logic [39:0] o_stop_hz, // programmed stop frequency
	output logic [39:0] o_span_hz, // stop minus start
	output logic [39:0] o_centre_hz, // midpoint of start and stop
	output logic [7:0] o_status, // serial-poll status byte
	output sfp_pkg::sfp_byte_s o_tx // readback digit stream
);
	logic rst_m_r, rst_s_r; // reset release pair
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_m_r <= 1'b0;
			rst_s_r <= 1'b0;
		end else begin
			rst_m_r <= 1'b1;
			rst_s_r <= rst_m_r;
		end
	end

	// fold to upper case so mixed case compares alike
	function automatic logic [7:0] up(input logic [7:0] c);
		up = (c >= 8'h61 && c <= 8'h7a) ? (c - 8'h20) : c;
	endfunction : up

	sfp_pkg::sfp_state_e st_r, st_nxt;
	logic [7:0] first_r, first_nxt; // first letter of a unit
	logic [63:0] mant_r, mant_nxt; // digits without point
	logic [3:0] frac_r, frac_nxt; // digits after the point
	logic seen_pt_r, seen_pt_nxt;
	logic [63:0] hz_r, hz_nxt; // scaled request in Hz
	logic [39:0] stop_r, stop_nxt;
	logic [31:0] cnt_r, cnt_nxt; // settle timer
	logic settled_r, settled_nxt;
	logic [39:0] txv_r, txv_nxt; // value being sent
	logic [39:0] div_r, div_nxt; // decimal place weight
	sfp_pkg::sfp_byte_s tx_r, tx_nxt;
	logic [7:0] c;
	logic [63:0] khz, base, lo, hi, mul, scale;
	logic [63:0] step; // grid step in Hz for the active band

	// unit scale with fraction digits divided back out
	function automatic logic [63:0] pow10(input logic [3:0] n);
		pow10 = 64'h1;
		for (int k = 0; k < 12; k++) begin
			if (k < n) pow10 = pow10 * 64'ha;
		end
	endfunction : pow10

	// next-state logic of the command sequencer
	always_comb begin
		c = up(i_rx.data);
		st_nxt = st_r;
		first_nxt = first_r;
		mant_nxt = mant_r;
		frac_nxt = frac_r;
		seen_pt_nxt = seen_pt_r;
		hz_nxt = hz_r;
		stop_nxt = stop_r;
		cnt_nxt = cnt_r;
		settled_nxt = settled_r;
		txv_nxt = txv_r;
		div_nxt = div_r;
		tx_nxt = '0;
		scale = 64'h0;
		khz = hz_r / 64'd1000;
		// band multiplier by kHz value
		mul = (khz < {24'h0, `SFP_BAND1_EDGE_KHZ}) ? 64'h1 :
			(khz < {24'h0, `SFP_BAND2_EDGE_KHZ}) ? 64'h2 : 64'h3;
		// grid worked in Hz so sub-kHz parts of the request still count when rounding
		step = mul * 64'd1000;
		base = hz_r / step;
		lo = base * step;
		hi = lo + step;
		if (i_poll) settled_nxt = 1'b0;
		case (st_r)
			sfp_pkg::SFP_IDLE: begin
				if (i_rx.valid && (c == "F" || c == "C")) begin
					first_nxt = c;
					st_nxt = (c == "F") ? sfp_pkg::SFP_CODE2 : sfp_pkg::SFP_CS2;
				end
			end
			sfp_pkg::SFP_CS2: begin
				if (i_rx.valid) begin
					if (c == "S") settled_nxt = 1'b0;
					st_nxt = sfp_pkg::SFP_IDLE;
				end
			end
			sfp_pkg::SFP_CODE2: begin
				if (i_rx.valid) begin
					mant_nxt = '0;
					frac_nxt = '0;
					seen_pt_nxt = 1'b0;
					st_nxt = (c == "B") ? sfp_pkg::SFP_NUM : sfp_pkg::SFP_IDLE;
				end
			end
			sfp_pkg::SFP_NUM: begin
				if (i_rx.valid) begin
					// digits pile up as sent; the value takes its scale only at the unit
					if (c >= "0" && c <= "9") begin
						if (!(seen_pt_r && frac_r == `SFP_FRAC_MAX)) begin
							mant_nxt = mant_r * 64'ha + {56'h0, c - 8'h30};
							if (seen_pt_r) frac_nxt = frac_r + 4'h1;
						end
					end else if (c == ".") begin
						seen_pt_nxt = 1'b1;
					end else if (c == "O") begin
						st_nxt = sfp_pkg::SFP_SUFFIX2;
					end else if (c == "G" || c == "M" || c == "K" || c == "H") begin
						first_nxt = c;
						st_nxt = sfp_pkg::SFP_UNIT2;
					end else begin
						st_nxt = sfp_pkg::SFP_IDLE;
					end
				end
			end
			sfp_pkg::SFP_UNIT2: begin
				if (i_rx.valid) begin
					case (first_r)
						"G": scale = 64'd1000000000;
						"M": scale = 64'd1000000;
						"K": scale = 64'd1000;
						default: scale = 64'd1;
					endcase
					hz_nxt = mant_r * scale / pow10(frac_r);
					st_nxt = (c == "Z") ? sfp_pkg::SFP_CALC : sfp_pkg::SFP_IDLE;
				end
			end
			sfp_pkg::SFP_CALC: begin
				// tie goes up; either neighbour is allowed
				stop_nxt = 40'(((hz_r - lo) < (hi - hz_r)) ? lo : hi);
				cnt_nxt = 32'(`SFP_SETTLE_CYC);
				st_nxt = sfp_pkg::SFP_SETTLE;
			end
			sfp_pkg::SFP_SETTLE: begin
				if (cnt_r == 32'h0) begin
					settled_nxt = 1'b1;
					st_nxt = sfp_pkg::SFP_IDLE;
				end else begin
					cnt_nxt = cnt_r - 32'h1;
				end
			end
			sfp_pkg::SFP_SUFFIX2: begin
				if (i_rx.valid) begin
					txv_nxt = stop_r;
					div_nxt = 40'd100000000000;
					st_nxt = (c == "A") ? sfp_pkg::SFP_SEND : sfp_pkg::SFP_IDLE;
				end
			end
			sfp_pkg::SFP_SEND: begin
				// decimal Hz digits, most significant first, fixed width
				tx_nxt.valid = 1'b1;
				tx_nxt.data = 8'h30 + 8'(txv_r / div_r);
				txv_nxt = txv_r % div_r;
				div_nxt = div_r / 40'd10;
				if (div_r == 40'd1) st_nxt = sfp_pkg::SFP_IDLE;
			end
			default: st_nxt = sfp_pkg::SFP_IDLE;
		endcase
		if (st_r == sfp_pkg::SFP_SETTLE && cnt_r == 32'h0) settled_nxt = 1'b1;
	end

	// state registers
	always_ff @(posedge i_sys_clk or negedge rst_s_r) begin
		if (!rst_s_r) begin
			st_r <= sfp_pkg::SFP_IDLE;
			first_r <= 8'h00;
			mant_r <= 64'h0;
			frac_r <= 4'h0;
			seen_pt_r <= 1'b0;
			hz_r <= 64'h0;
			stop_r <= 40'h0;
			cnt_r <= 32'h0;
			settled_r <= 1'b0;
			txv_r <= 40'h0;
			div_r <= 40'h1;
			tx_r <= '0;
		end else begin
			st_r <= st_nxt;
			first_r <= first_nxt;
			mant_r <= mant_nxt;
			frac_r <= frac_nxt;
			seen_pt_r <= seen_pt_nxt;
			hz_r <= hz_nxt;
			stop_r <= stop_nxt;
			cnt_r <= cnt_nxt;
			settled_r <= settled_nxt;
			txv_r <= txv_nxt;
			div_r <= div_nxt;
			tx_r <= tx_nxt;
		end
	end

	// span and centre follow the stop register
	assign o_stop_hz = stop_r;
	assign o_span_hz = stop_r - i_start_hz;
	assign o_centre_hz = 40'(({1'b0, stop_r} + {1'b0, i_start_hz}) >> 1);
	assign o_status = `SFP_STB_RESET | (8'(settled_r) << `SFP_STB_SETTLED_BIT);
	assign o_tx = tx_r;

	// last cycle of the settle wait
	sequence s_settle_done;
		st_r == sfp_pkg::SFP_SETTLE && cnt_r == 32'h0;
	endsequence
	a_settle_sets: assert property (@(posedge i_sys_clk) disable iff (!rst_s_r)
		s_settle_done |=> o_status[3])
		else $error("settled flag not set after settle");
	a_clear_drops: assert property (@(posedge i_sys_clk) disable iff (!rst_s_r)
		(st_r == sfp_pkg::SFP_CS2 && i_rx.valid && up(i_rx.data) == "S" && st_r != sfp_pkg::SFP_SETTLE)
		|=> !o_status[3])
		else $error("clear status left flag set");
	a_flag_latched: assert property (@(posedge i_sys_clk) disable iff (!rst_s_r)
		(o_status[3] && !i_poll && st_r != sfp_pkg::SFP_CS2) |=> o_status[3])
		else $error("settled flag dropped by itself");
	a_grid_band: assert property (@(posedge i_sys_clk) disable iff (!rst_s_r)
		(st_r == sfp_pkg::SFP_SETTLE && stop_r >= 40'd6600000000 && stop_r < 40'd12300000000)
		|-> ((stop_r / 40'd1000) % 40'd2 == 40'd0))
		else $error("middle band stop off grid");
	a_grid_top: assert property (@(posedge i_sys_clk) disable iff (!rst_s_r)
		(st_r == sfp_pkg::SFP_SETTLE && stop_r >= 40'd12300003000)
		|-> ((stop_r / 40'd1000) % 40'd3 == 40'd0))
		else $error("top band stop off grid");
	a_khz_step: assert property (@(posedge i_sys_clk) disable iff (!rst_s_r)
		(st_r == sfp_pkg::SFP_SETTLE) |-> (stop_r % 40'd1000 == 40'd0))
		else $error("stop not on kHz step");
	a_centre_mid: assert property (@(posedge i_sys_clk) disable iff (!rst_s_r)
		((({1'b0, o_stop_hz} + {1'b0, i_start_hz}) - ({1'b0, o_centre_hz} << 1)) <= 41'd1))
		else $error("centre not midway between start and stop");
	a_span_diff: assert property (@(posedge i_sys_clk) disable iff (!rst_s_r)
		(40'(o_span_hz + i_start_hz) == o_stop_hz))
		else $error("span not stop minus start");
	a_bit_three: assert property (@(posedge i_sys_clk) disable iff (!rst_s_r)
		(o_status & 8'hf7) == 8'h00)
		else $error("status bits other than 3 set");
endmodule : sfp_parser

// File: bench/sfp_ctrl_model.sv
// controller model: sends ascii command strings to the parser, one char a cycle
// assumes the bench clock; the parser gives no back-pressure, so callers wait out settling
`timescale 1ns/100ps
module sfp_ctrl_model (
	input wire logic i_sys_clk,
	output sfp_pkg::sfp_byte_s o_rx
);
	// idle with valid low
	initial o_rx = '{valid: 1'b0, data: 8'h00};
	// one char per falling edge, whole string back to back
	task automatic send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			@(negedge i_sys_clk);
			o_rx.valid = 1'b1;
			o_rx.data = s[i];
		end
		@(negedge i_sys_clk);
		o_rx.valid = 1'b0;
		// stale byte inverted so a released line never repeats the last char
		o_rx.data = ~o_rx.data;
	endtask : send
endmodule : sfp_ctrl_model

// File: bench/tb_sweep_stop_freq_command_parser.sv
// bench for the stop-frequency command parser
// assumes the controller model drives i_rx and the bench drives the rest at falling edges
`timescale 1ns/100ps
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin mismatches++; $display("wrong value at %0t: %s", $time, m); end end
module tb_sweep_stop_freq_command_parser;
	logic i_sys_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_poll = 1'b0;
	logic [39:0] i_start_hz = 40'h0;
	sfp_pkg::sfp_byte_s rx;
	sfp_pkg::sfp_byte_s tx;
	logic [39:0] stop_hz;
	logic [39:0] span_hz;
	logic [39:0] centre_hz;
	logic [7:0] status;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	// 125 MHz clock
	initial forever #4 i_sys_clk = ~i_sys_clk;
	sfp_ctrl_model u_ctrl (.i_sys_clk(i_sys_clk), .o_rx(rx));
	sfp_parser dut (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_rx(rx), .i_poll(i_poll),
		.i_start_hz(i_start_hz), .o_stop_hz(stop_hz), .o_span_hz(span_hz), .o_centre_hz(centre_hz),
		.o_status(status), .o_tx(tx));
	// hang guard, far above the fewer than one thousand cycles the run needs
	always @(posedge i_sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			finish_test();
		end
	end
	task automatic finish_test();
		if (mismatches == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : finish_test
	// send a cleared-status command, check rounding, then wait a bounded time for settling
	task automatic set_stop(input string s, input logic [39:0] exp);
		u_ctrl.send(s);
		repeat (3) @(negedge i_sys_clk);
		`CHK(stop_hz, exp, "stop frequency")
		`CHK(status, 8'h00, "flag before settle")
		for (int i = 0; i < 300 && status[3] !== 1'b1; i++) @(negedge i_sys_clk);
		`CHK(status, 8'h08, "settled flag")
	endtask : set_stop
	// every unit terminator, mixed case, same middle-band value
	task automatic test_units();
		string cmds[4] = '{"CSFB11.232334GZ", "csfb11232.334mz", "CsFb11232334kZ", "cSfB11232334000Hz"};
		foreach (cmds[i]) set_stop(cmds[i], 40'd11232334000);
	endtask : test_units
	// top band off-grid request, plus span and centre against the start frequency
	task automatic test_top_band();
		i_start_hz = 40'd6000000000;
		set_stop("CSFB12.4GZ", 40'd12399999000);
		`CHK(span_hz, 40'd6399999000, "span")
		`CHK(centre_hz, 40'd9199999500, "centre")
	endtask : test_top_band
	// low band rounding to whole kHz, flag latched until a poll
	task automatic test_low_poll();
		set_stop("CSFB1234567HZ", 40'd1235000);
		repeat (20) @(negedge i_sys_clk);
		`CHK(status, 8'h08, "flag held")
		i_poll = 1'b1;
		@(negedge i_sys_clk);
		i_poll = 1'b0;
		@(negedge i_sys_clk);
		`CHK(status, 8'h00, "flag after poll")
	endtask : test_low_poll
	// readback in hertz as decimal digits
	task automatic test_readback();
		logic [39:0] val;
		int n;
		val = 40'h0;
		n = 0;
		u_ctrl.send("fBoA");
		for (int i = 0; i < 40; i++) begin
			@(negedge i_sys_clk);
			if (tx.valid === 1'b1) begin
				val = val * 10 + 40'(tx.data - 8'h30);
				n++;
			end
		end
		`CHK(val, 40'd1235000, "readback value")
		`CHK(n, 12, "readback digits")
	endtask : test_readback
	// main sequence: reset for 8 cycles, then the scenarios
	initial begin
		repeat (8) @(negedge i_sys_clk);
		i_resetn = 1'b1;
		repeat (3) @(negedge i_sys_clk);
		test_units();
		test_top_band();
		test_low_poll();
		test_readback();
		finish_test();
	end
endmodule : tb_sweep_stop_freq_command_parser
